//--- src/pmcs_csr.sv
// power-management control/status register with wake output
`include "pmcs_params.svh"
`default_nettype none
module pmcs_csr
	import pmcs_pkg::*;
(
	// clock and resets
	input  wire logic               i_clock,
	input  wire logic               i_nrst,
	input  wire logic               i_aux_nrst,
	// configuration access
	input  wire pmcs_pkg::pmcs_cfg_s  i_cfg,
	output logic [15:0]             o_rdata,
	// capabilities and data-register side
	input  wire pmcs_pkg::pmcs_caps_s i_caps,
	input  wire logic [1:0]         i_data_scale,
	// power events
	input  wire logic               i_power_event,
	// outputs
	output logic                    o_wake_n,
	output logic [1:0]              o_power_state,
	output logic [3:0]              o_data_select
);
	import pmcs_pkg::*;

	////////////////////////////////////////////////////////////////
	// decode
	logic        hit;
	logic        wr_lo;
	logic        wr_hi;
	logic        wake_cold;
	logic        status;
	logic        enable;
	logic        state_ok;
	logic [1:0]  wstate;
	logic [3:0]  select_q;
	logic [3:0]  select_d;
	logic [1:0]  state_q;
	logic [1:0]  state_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic        wake_n_q;
	logic        wake_n_d;

	assign hit       = (i_cfg.addr == (`PMCS_CAP_BASE + `PMCS_CSR_OFFSET));
	assign wr_lo     = i_cfg.wr & hit & i_cfg.be[0];
	assign wr_hi     = i_cfg.wr & hit & i_cfg.be[1];
	assign wake_cold = i_caps.wake_support_mask[`PMCS_WAKE_COLD_BIT];
	assign wstate    = i_cfg.wdata[`PMCS_STATE_HI:`PMCS_STATE_LO];

	// D1/D2 are optional; D0 and D3hot always accepted
	always_comb
	begin
		case (wstate)
			PMCS_D1: state_ok = i_caps.d1_support;
			PMCS_D2: state_ok = i_caps.d2_support;
			default: state_ok = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// sticky status and enable
	pmcs_sticky pmcs_sticky_inst
	(
		.i_clock      (i_clock),
		.i_nrst       (i_nrst),
		.i_aux_nrst   (i_aux_nrst),
		.i_wake_cold  (wake_cold),
		.i_event      (i_power_event),
		.i_status_clr (wr_hi & i_cfg.wdata[`PMCS_STATUS_BIT]),
		.i_enable_wr  (wr_hi),
		.i_enable_val (i_cfg.wdata[`PMCS_ENABLE_BIT]),
		.o_status     (status),
		.o_enable     (enable)
	);

	////////////////////////////////////////////////////////////////
	// control fields, read data and wake output: next values
	always_comb
	begin
		select_d = select_q;
		state_d  = state_q;
		if (wr_hi && i_caps.data_reg_present)
			select_d = i_cfg.wdata[`PMCS_SELECT_HI:`PMCS_SELECT_LO];
		if (wr_lo && state_ok)
			state_d = wstate;
		// reserved bits read zero whatever software wrote
		rdata_d = 16'h0000;
		rdata_d[`PMCS_STATUS_BIT] = status;
		rdata_d[`PMCS_SCALE_HI:`PMCS_SCALE_LO] = i_caps.data_reg_present ? i_data_scale : `PMCS_SCALE_RST;
		rdata_d[`PMCS_SELECT_HI:`PMCS_SELECT_LO] = i_caps.data_reg_present ? select_q : `PMCS_SELECT_RST;
		rdata_d[`PMCS_ENABLE_BIT] = enable;
		rdata_d[`PMCS_STATE_HI:`PMCS_STATE_LO] = state_q;
		// open-drain style, active low
		wake_n_d = ~(status & enable);
	end

	// register them; power state and selector follow the bus reset
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			select_q <= `PMCS_SELECT_RST;
			state_q  <= `PMCS_STATE_RST;
			rdata_q  <= 16'h0000;
			wake_n_q <= 1'b1;
		end
		else
		begin
			select_q <= select_d;
			state_q  <= state_d;
			rdata_q  <= rdata_d;
			wake_n_q <= wake_n_d;
		end
	end

	assign o_rdata       = rdata_q;
	assign o_wake_n      = wake_n_q;
	assign o_power_state = state_q;
	assign o_data_select = select_q;

	////////////////////////////////////////////////////////////////
	// assertions
	property p_event_sets;
		@(posedge i_clock) disable iff (!i_nrst)
		i_power_event |=> status;
	endproperty
	a_event_sets: assert property (p_event_sets) else $error("event did not set status");

	property p_clear_one;
		@(posedge i_clock) disable iff (!i_nrst)
		(wr_hi && i_cfg.wdata[`PMCS_STATUS_BIT] && !i_power_event) |=> !status;
	endproperty
	a_clear_one: assert property (p_clear_one) else $error("write one failed to clear status");

	property p_zero_keeps;
		@(posedge i_clock) disable iff (!i_nrst)
		(status && !(wr_hi && i_cfg.wdata[`PMCS_STATUS_BIT])) |=> status;
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("status lost without a clearing write");

	property p_wake_gate;
		@(posedge i_clock) disable iff (!i_nrst)
		!enable |=> o_wake_n;
	endproperty
	a_wake_gate: assert property (p_wake_gate) else $error("wake asserted while disabled");

	property p_wake_follows;
		@(posedge i_clock) disable iff (!i_nrst)
		(status && enable) |=> !o_wake_n;
	endproperty
	a_wake_follows: assert property (p_wake_follows) else $error("wake not asserted");

	property p_scale_zero;
		@(posedge i_clock) disable iff (!i_nrst)
		!i_caps.data_reg_present |=> (o_rdata[14:9] == 6'h00);
	endproperty
	a_scale_zero: assert property (p_scale_zero) else $error("scale or select nonzero without data register");

	property p_select_write;
		@(posedge i_clock) disable iff (!i_nrst)
		(wr_hi && i_caps.data_reg_present) |=> (select_q == $past(i_cfg.wdata[12:9]));
	endproperty
	a_select_write: assert property (p_select_write) else $error("selector not written");

	property p_state_write;
		@(posedge i_clock) disable iff (!i_nrst)
		(wr_lo && state_ok) |=> ##1 (o_rdata[1:0] == $past(wstate, 2));
	endproperty
	a_state_write: assert property (p_state_write) else $error("power state not read back");

	property p_bad_state;
		@(posedge i_clock) disable iff (!i_nrst)
		(wr_lo && !state_ok) |=> $stable(state_q);
	endproperty
	a_bad_state: assert property (p_bad_state) else $error("unsupported state accepted");

	property p_wake_clear;
		@(posedge i_clock) disable iff (!i_nrst)
		(wr_hi && i_cfg.wdata[`PMCS_STATUS_BIT] && !i_power_event) |=> ##1 o_wake_n;
	endproperty
	a_wake_clear: assert property (p_wake_clear) else $error("wake still asserted after status clear");

	property p_select_locked;
		@(posedge i_clock) disable iff (!i_nrst)
		(wr_hi && !i_caps.data_reg_present) |=> $stable(select_q);
	endproperty
	a_select_locked: assert property (p_select_locked) else $error("selector written without data register");

	// writes to other offsets must leave power state, selector and enable alone
	property p_miss_ignored;
		@(posedge i_clock) disable iff (!i_nrst)
		(i_cfg.wr && !hit) |=> ($stable(state_q) && $stable(select_q) && $stable(enable));
	endproperty
	a_miss_ignored: assert property (p_miss_ignored) else $error("write to another offset changed the register");

	// sticky bits ride out a bus reset only with cold wake support; only the aux reset disables these two
	property p_sticky_hold;
		@(posedge i_clock) disable iff (!i_aux_nrst)
		(!i_nrst && wake_cold && !i_power_event && !wr_hi)
		|=> ((status == $past(status)) && (enable == $past(enable)));
	endproperty
	a_sticky_hold: assert property (p_sticky_hold) else $error("sticky bits lost across bus reset");

	property p_flush_plain;
		@(posedge i_clock) disable iff (!i_aux_nrst)
		(!i_nrst && !wake_cold) |=> (!status && !enable);
	endproperty
	a_flush_plain: assert property (p_flush_plain) else $error("status or enable kept over bus reset");
endmodule
`default_nettype wire

//--- src/pmcs_params.svh
// offsets, field positions and reset values of the power-management control/status register
`ifndef PMCS_PARAMS_SVH
`define PMCS_PARAMS_SVH

// register placement within configuration space
`define PMCS_CAP_BASE        8'h34
`define PMCS_CSR_OFFSET      8'h04
`define PMCS_CSR_WIDTH       16

// field positions
`define PMCS_STATUS_BIT      15
`define PMCS_SCALE_HI        14
`define PMCS_SCALE_LO        13
`define PMCS_SELECT_HI       12
`define PMCS_SELECT_LO       9
`define PMCS_ENABLE_BIT      8
`define PMCS_RSVD_HI         7
`define PMCS_RSVD_LO         2
`define PMCS_STATE_HI        1
`define PMCS_STATE_LO        0

// wake-from-D3cold support is the top bit of the wake-support field
`define PMCS_WAKE_COLD_BIT   4

// reset values
`define PMCS_SELECT_RST      4'h0
`define PMCS_SCALE_RST       2'h0
`define PMCS_STATE_RST       2'h0

`endif

//--- src/pmcs_pkg.sv
// types shared by the power-management control/status block
`default_nettype none
package pmcs_pkg;

	// power-state encodings
	typedef enum logic [1:0]
	{
		PMCS_D0    = 2'b00,
		PMCS_D1    = 2'b01,
		PMCS_D2    = 2'b10,
		PMCS_D3HOT = 2'b11
	} pmcs_state_e;

	// one configuration access to the register
	typedef struct packed
	{
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [1:0]  be;
		logic [15:0] wdata;
	} pmcs_cfg_s;

	// capability inputs that steer the register
	typedef struct packed
	{
		logic [4:0] wake_support_mask;
		logic       d1_support;
		logic       d2_support;
		logic       data_reg_present;
	} pmcs_caps_s;

endpackage
`default_nettype wire

//--- src/pmcs_sticky.sv
// sticky power-event status and enable bits, reset by auxiliary power-on and, without cold wake support, by a bus reset
`include "pmcs_params.svh"
`default_nettype none
module pmcs_sticky
(
	// clock and resets
	input  wire logic i_clock,
	input  wire logic i_nrst,
	input  wire logic i_aux_nrst,
	// control
	input  wire logic i_wake_cold,
	input  wire logic i_event,
	input  wire logic i_status_clr,
	input  wire logic i_enable_wr,
	input  wire logic i_enable_val,
	// state
	output logic      o_status,
	output logic      o_enable
);
	logic status_q;
	logic status_d;
	logic enable_q;
	logic enable_d;
	logic flush;

	// without cold wake, a bus reset clears the bits; with it, they ride it out
	assign flush = ~i_wake_cold & ~i_nrst;

	// next values: an event in the clear cycle wins
	always_comb
	begin
		status_d = status_q;
		enable_d = enable_q;
		if (flush)
		begin
			status_d = 1'b0;
			enable_d = 1'b0;
		end
		else
		begin
			if (i_status_clr)
				status_d = 1'b0;
			if (i_event)
				status_d = 1'b1;
			if (i_enable_wr)
				enable_d = i_enable_val;
		end
	end

	// only auxiliary power-on resets the sticky bits asynchronously
	always_ff @(posedge i_clock or negedge i_aux_nrst)
	begin
		if (!i_aux_nrst)
		begin
			status_q <= 1'b0;
			enable_q <= 1'b0;
		end
		else
		begin
			status_q <= status_d;
			enable_q <= enable_d;
		end
	end

	assign o_status = status_q;
	assign o_enable = enable_q;
endmodule
`default_nettype wire

//--- verification/pmcs_host_model.sv
// host-side model issuing configuration writes to the power-management register
`default_nettype none
module pmcs_host_model
	import pmcs_pkg::*;
(
	// clock
	input  wire logic               i_clock,
	// configuration access
	output var pmcs_pkg::pmcs_cfg_s o_cfg
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////
	// bus idles low; data is inverted after each write so stale data never looks valid
	initial o_cfg = '0;

	// one write held across exactly one sampling edge; reserved bits always zero
	task automatic cfg_write(input logic [7:0] addr, input logic [1:0] be, input logic [15:0] data);
		o_cfg.addr  = addr;
		o_cfg.be    = be;
		o_cfg.wdata = data & 16'hFF03;
		o_cfg.rd    = 1'b0;
		o_cfg.wr    = 1'b1;
		@(negedge i_clock);
		o_cfg.wr    = 1'b0;
		o_cfg.wdata = ~o_cfg.wdata;
	endtask
endmodule
`default_nettype wire

//--- verification/tb_pmcs_csr.sv
// self-checking bench for the power-management control/status register
`default_nettype none
module tb_pmcs_csr;
	timeunit 1ns;
	timeprecision 1ps;
	import pmcs_pkg::*;

	logic        i_clock;
	logic        i_nrst;
	logic        i_aux_nrst;
	logic        i_power_event;
	pmcs_cfg_s   cfg;
	pmcs_caps_s  caps;
	logic [1:0]  scale;
	logic [15:0] rdata;
	logic        wake_n;
	logic [1:0]  pstate;
	logic [3:0]  dsel;
	int          err_total;
	int          comparisons;
	// expected register contents
	logic        st;
	logic        en;
	logic [3:0]  sel;
	logic [1:0]  exp_state;

	////////////////////////////////////////////////////////////////////////////////
	pmcs_csr pmcs_csr_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_aux_nrst(i_aux_nrst), .i_cfg(cfg),
		.o_rdata(rdata), .i_caps(caps), .i_data_scale(scale), .i_power_event(i_power_event),
		.o_wake_n(wake_n), .o_power_state(pstate), .o_data_select(dsel));
	pmcs_host_model pmcs_host_model_inst (.i_clock(i_clock), .o_cfg(cfg));

	// free-running 100 MHz clock
	initial
	begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end

	// scale and select read zero when no data register sits behind them
	function automatic logic [15:0] exp_rdata();
		return {st, caps.data_reg_present ? scale : 2'h0, caps.data_reg_present ? sel : 4'h0, en, 6'h00, exp_state};
	endfunction

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// three edges cover the two-cycle read latency with margin
	task automatic settle_check();
		repeat (3) @(negedge i_clock);
		check("rdata", rdata, exp_rdata());
		check("wake_n", {15'h0000, wake_n}, {15'h0000, ~(st & en)});
		check("power_state", {14'h0000, pstate}, {14'h0000, exp_state});
		check("data_select", {12'h000, dsel}, {12'h000, sel});
	endtask

	// bus reset, optionally with auxiliary power-on reset as well
	task automatic do_reset(input logic aux);
		@(negedge i_clock);
		i_nrst = 1'b0;
		i_aux_nrst = ~aux;
		repeat (3) @(negedge i_clock);
		i_nrst = 1'b1;
		i_aux_nrst = 1'b1;
		if (aux || !caps.wake_support_mask[4])
		begin
			st = 1'b0;
			en = 1'b0;
		end
		sel = 4'h0;
		exp_state = 2'h0;
		settle_check();
	endtask

	// one random write, with or without a power event, mostly to the mapped offset
	task automatic rand_op();
		logic [15:0] d;
		logic [1:0]  be;
		logic        hit;
		logic        ev;
		d = 16'($urandom());
		be = 2'($urandom());
		hit = ($urandom_range(3) != 0);
		ev = ($urandom_range(2) == 0);
		scale = 2'($urandom());
		if (hit && be[1])
		begin
			if (d[15])
				st = 1'b0;
			en = d[8];
			if (caps.data_reg_present)
				sel = d[12:9];
		end
		if (hit && be[0] && (d[0] == d[1] || (d[0] && caps.d1_support) || (d[1] && caps.d2_support)))
			exp_state = d[1:0];
		// a power event wins over a same-cycle clear
		if (ev)
			st = 1'b1;
		@(negedge i_clock);
		i_power_event = ev;
		pmcs_host_model_inst.cfg_write(hit ? 8'h38 : 8'($urandom_range(8'h39, 8'hFF)), be, d);
		i_power_event = 1'b0;
		settle_check();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence: corner capability sets first, then random ones
	initial
	begin
		i_nrst = 1'b0;
		i_aux_nrst = 1'b0;
		i_power_event = 1'b0;
		caps = '0;
		scale = 2'h0;
		{st, en, sel, exp_state} = '0;
		err_total = 0;
		comparisons = 0;
		void'($urandom(32'h67DE));
		repeat (20) @(negedge i_clock);
		i_nrst = 1'b1;
		i_aux_nrst = 1'b1;
		settle_check();
		for (int k = 0; k < 8; k++)
		begin
			caps = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom());
			do_reset(k == 4);
			repeat (40) rand_op();
		end
		conclude();
	end

	// watchdog against a hung run
	initial
	begin
		#200000;
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
